// File: dv/rsc_far_model.sv
/*
  far side of the reset-source block: supply monitor and watchdog
  assumes the bench calls its tasks and supplies ref_clk
*/
`timescale 1ns/1ps
`default_nettype none
module rsc_far_model (
  input wire logic ref_clk,
  output logic supply_low,
  output logic wdt_timeout
);
  initial begin
    supply_low = 1'b0;
    wdt_timeout = 1'b0;
  end
  // comparator level, not aligned to the clock
  task automatic set_low(input logic v);
    @(posedge ref_clk);
    #7 supply_low = v;
  endtask
  // one-cycle overflow pulse
  task automatic overflow();
    @(posedge ref_clk);
    wdt_timeout <= 1'b1;
    @(posedge ref_clk);
    wdt_timeout <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: dv/test_reset_source_control.sv
/*
  bench of the reset-source block: registers, reset sources, flags
  assumes rsc_top and rsc_far_model, short soft and debounce counts
*/
`timescale 1ns/1ps
`include "rsc_cfg.svh"
`default_nettype none
module test_reset_source_control;
  localparam int S = 8;
  localparam int L = 10;
  localparam logic [6:0] FULL = 7'h5f;
  logic ref_clk, nrst, ce, s_awvalid, s_wvalid, s_bready;
  logic s_arvalid, s_rready, s_awready, s_wready, s_bvalid;
  logic s_arready, s_rvalid, supply_low, wdt_timeout, sleep_entry;
  logic dev_reset, wdt_enable, timeout_status_flag, power_down_flag;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, lvr_level_sel;
  rsc_pkg::rsc_mode_t cpu_mode;
  rsc_pkg::rsc_init_t init_req, ir_at_dr;
  int err_total = 0;
  int samples_checked = 0;
  int dr_cnt = 0;
  int ps_cnt = 0;
  int cyc = 0;
  logic [7:0] codes [4] = '{8'h55, 8'h33, 8'h99, 8'haa};

  rsc_top #(.SRESET_CYC(S), .LVR_CYC(L)) dut_u (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .supply_low(supply_low),
    .wdt_timeout(wdt_timeout),
    .sleep_entry(sleep_entry),
    .cpu_mode(cpu_mode),
    .dev_reset(dev_reset),
    .init_req(init_req),
    .lvr_level_sel(lvr_level_sel),
    .wdt_enable(wdt_enable),
    .timeout_status_flag(timeout_status_flag),
    .power_down_flag(power_down_flag)
  );
  rsc_far_model far_u (
    .ref_clk(ref_clk),
    .supply_low(supply_low),
    .wdt_timeout(wdt_timeout)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task report_and_stop();
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // reset pulses, captured init pattern, pc/sp-only pulses, hang limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (dev_reset === 1'b1) begin
      dr_cnt <= dr_cnt + 1;
      ir_at_dr <= init_req;
    end
    if (init_req === 7'h60) ps_cnt <= ps_cnt + 1;
    if (cyc == 6000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do @(posedge ref_clk); while (!(s_awready === 1'b1 && s_wready === 1'b1));
    s_awvalid <= 1'b0;
    s_wvalid <= 1'b0;
    while (s_bvalid !== 1'b1) @(posedge ref_clk);
    chk("bresp", 32'h0000_0000, {30'h0000_0000, s_bresp});
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] r);
    @(posedge ref_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge ref_clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1) @(posedge ref_clk);
    chk("rdata", {24'h00_0000, e}, s_rdata);
    chk("rresp", {30'h0000_0000, r}, {30'h0000_0000, s_rresp});
    s_rready <= 1'b0;
  endtask

  task automatic no_rst(input int n);
    int c0;
    c0 = dr_cnt;
    repeat (n) @(posedge ref_clk);
    chk("no_reset", 32'h0000_0000, 32'(dr_cnt - c0));
  endtask

  task automatic expect_rst(input int lo, input int hi);
    int c0;
    c0 = dr_cnt;
    no_rst(lo);
    repeat (hi - lo) @(posedge ref_clk);
    chk("reset_pulse", 32'h0000_0001, 32'(dr_cnt - c0));
    chk("init_full", {25'h000_0000, FULL}, {25'h000_0000, ir_at_dr});
  endtask

  initial begin
    int p0;
    nrst = 1'b0;
    ce = 1'b1;
    s_awvalid = 1'b0;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'hf;
    sleep_entry = 1'b0;
    cpu_mode = rsc_pkg::RSC_FAST;
    repeat (8) @(posedge ref_clk);
    chk("init_por", {25'h000_0000, FULL}, {25'h000_0000, init_req});
    nrst <= 1'b1;
    rd(`RSC_A_THR, 8'h55, 2'b00);
    rd(`RSC_A_FLG, 8'h00, 2'b00);
    rd(`RSC_A_GRD, 8'h55, 2'b00);
    rd(`RSC_A_WEN, 8'h0a, 2'b00);
    rd(`RSC_A_STS, 8'h00, 2'b00);
    rd(8'h14, 8'h00, 2'b10);
    for (int i = 0; i < 4; i++) begin
      wr(`RSC_A_THR, {24'h00_0000, codes[i]});
      chk("level", 32'(i), {30'h0000_0000, lvr_level_sel});
    end
    wr(`RSC_A_THR, 32'h0000_0012);
    expect_rst(S, S + 8);
    rd(`RSC_A_THR, 8'h55, 2'b00);
    wr(`RSC_A_FLG, 32'h0000_00ff);
    rd(`RSC_A_FLG, 8'h02, 2'b00);
    wr(`RSC_A_FLG, 32'h0000_0000);
    rd(`RSC_A_FLG, 8'h00, 2'b00);
    for (int i = 0; i < 2; i++) begin
      wr(i ? `RSC_A_WEN : `RSC_A_GRD, i ? 32'h0000_001f : 32'h0000_005a);
      ce <= 1'(i);
      no_rst(i ? 0 : 3 * S);
      ce <= 1'b1;
      expect_rst(S, S + 8);
      rd(`RSC_A_FLG, i ? 8'h01 : 8'h08, 2'b00);
      wr(`RSC_A_FLG, 32'h0000_0000);
    end
    s_wstrb <= 4'he;
    wr(`RSC_A_THR, 32'h0000_0012);
    s_wstrb <= 4'hf;
    rd(`RSC_A_THR, 8'h55, 2'b00);
    wr(`RSC_A_WEN, 32'h0000_0015);
    chk("wdt_enable", 32'h0000_0000, {31'h0000_0000, wdt_enable});
    wr(`RSC_A_WEN, 32'h0000_000a);
    chk("wdt_enable", 32'h0000_0001, {31'h0000_0000, wdt_enable});
    wr(`RSC_A_THR, 32'h0000_0033);
    far_u.set_low(1'b1);
    expect_rst(L, L + 6);
    far_u.set_low(1'b0);
    rd(`RSC_A_THR, 8'h33, 2'b00);
    rd(`RSC_A_FLG, 8'h04, 2'b00);
    rd(`RSC_A_STS, 8'h00, 2'b00);
    far_u.set_low(1'b1);
    no_rst(L - 4);
    far_u.set_low(1'b0);
    no_rst(2 * L);
    cpu_mode <= rsc_pkg::RSC_SLEEP;
    far_u.set_low(1'b1);
    no_rst(3 * L);
    far_u.set_low(1'b0);
    no_rst(2 * L);
    cpu_mode <= rsc_pkg::RSC_FAST;
    far_u.overflow();
    expect_rst(0, 6);
    rd(`RSC_A_STS, 8'h01, 2'b00);
    rd(`RSC_A_THR, 8'h55, 2'b00);
    wr(`RSC_A_THR, 32'h0000_0099);
    cpu_mode <= rsc_pkg::RSC_IDLE;
    sleep_entry <= 1'b1;
    @(posedge ref_clk);
    sleep_entry <= 1'b0;
    p0 = ps_cnt;
    far_u.overflow();
    no_rst(6);
    chk("pc_sp", 32'h0000_0001, 32'(ps_cnt - p0));
    chk("to", 32'h0000_0001, {31'h0000_0000, timeout_status_flag});
    chk("pdf", 32'h0000_0001, {31'h0000_0000, power_down_flag});
    rd(`RSC_A_THR, 8'h99, 2'b00);
    cpu_mode <= rsc_pkg::RSC_FAST;
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("init_por", {25'h000_0000, FULL}, {25'h000_0000, init_req});
    nrst <= 1'b1;
    rd(`RSC_A_STS, 8'h00, 2'b00);
    rd(`RSC_A_THR, 8'h55, 2'b00);
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: hw/rsc_cfg.svh
/*
  constants of the reset-source block: offsets, fields, resets, timing
  assumes inclusion by hw/rsc_top.sv and by the bench
*/
// Functional notes
// - Four threshold codes pick 2.1, 2.55, 3.15 or 3.8 V; others invalid.
// - Invalid threshold code: reset after soft delay, register back to 0x55.
// - Supply low past debounce time resets device; threshold register kept.
// - Low-voltage reset sets flag bit 2; only software writing zero clears.
// - Invalid threshold reset sets flag bit 1; only software zero clears.
// - Flag register bits 7..4 read zero; bits 3..0 hold causes.
// - Watchdog time-out in fast/slow: full reset and time-out flag set.
// - Watchdog time-out in sleep/idle: clear PC and SP, set time-out flag.
// - Power-on clears time-out and power-down flags; low-voltage reset keeps.
// - Sleep/idle watchdog time-out leaves both status flags at one.
// - Power-on zeroes PC, masks interrupts, clears timers, pins as inputs.
// - Guard register not 0x55/0xAA: reset after delay, set its flag.
// - Watchdog code 10101 off, 01010 on, else delayed reset and flag.
// - Low-voltage detection is off in sleep and idle modes.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_A_THR 8'h00
`define RSC_A_FLG 8'h04
`define RSC_A_GRD 8'h08
`define RSC_A_WEN 8'h0c
`define RSC_A_STS 8'h10

`define RSC_THR_RST 8'h55
`define RSC_THR_V0 8'h55
`define RSC_THR_V1 8'h33
`define RSC_THR_V2 8'h99
`define RSC_THR_V3 8'haa
`define RSC_GRD_RST 8'h55
`define RSC_GRD_ALT 8'haa
`define RSC_WEN_RST 5'h0a
`define RSC_WEN_OFF 5'h15
`define RSC_WEN_ON 5'h0a

`define RSC_F_CONTROL_REGISTER_RESET_FLAG 3
`define RSC_F_LOW_VOLTAGE_RESET_FLAG 2
`define RSC_F_LRF 1
`define RSC_F_WRF 0
`define RSC_S_TO 0
`define RSC_S_PDF 1

`define RSC_CLK_MHZ 40
`define RSC_SRESET_US 100
`define RSC_LVR_US 120
`define RSC_SRESET_CYC (`RSC_SRESET_US * `RSC_CLK_MHZ)
`define RSC_LVR_CYC (`RSC_LVR_US * `RSC_CLK_MHZ)

`endif

// File: hw/rsc_pkg.sv
/*
  types of the reset-source block
  assumes no other package
*/
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_FAST = 2'b00,
    RSC_SLOW = 2'b01,
    RSC_IDLE = 2'b11,
    RSC_SLEEP = 2'b10
  } rsc_mode_t;

  typedef struct packed {
    logic pc_zero;
    logic sp_zero;
    logic sp_top;
    logic int_off;
    logic wdt_clr;
    logic tmr_off;
    logic io_in;
  } rsc_init_t;

  typedef struct packed {
    logic control_register_reset_flag;
    logic low_voltage_reset_flag;
    logic threshold_register_fault_flag;
    logic watchdog_register_fault_flag;
  } rsc_flags_t;
endpackage

// File: hw/rsc_top.sv
/*
  reset-source control: code checks, low-voltage qualify, watchdog
  reset by mode, cause flags, AXI4-Lite registers
  assumes supply_low is asynchronous; other inputs are on ref_clk
*/
`timescale 1ns/1ps
`include "rsc_cfg.svh"
`default_nettype none

module rsc_top #(
  parameter int SRESET_CYC = `RSC_SRESET_CYC,
  parameter int LVR_CYC = `RSC_LVR_CYC,
  parameter int CW = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic supply_low,
  input wire logic wdt_timeout,
  input wire logic sleep_entry,
  input wire rsc_pkg::rsc_mode_t cpu_mode,
  output logic dev_reset,
  output rsc_pkg::rsc_init_t init_req,
  output logic [1:0] lvr_level_sel,
  output logic wdt_enable,
  output logic timeout_status_flag,
  output logic power_down_flag
);
  localparam logic [CW-1:0] SR_N = CW'(SRESET_CYC);
  localparam logic [CW-1:0] LV_N = CW'(LVR_CYC);

  logic [7:0] thr_ff, grd_ff;
  logic [4:0] wen_ff;
  rsc_pkg::rsc_flags_t flg_ff;
  logic to_ff, pdf_ff;
  logic [CW-1:0] sr_cnt_ff, lv_cnt_ff;
  logic low_s1_ff, low_s2_ff;
  logic full_ff, lvr_cause_ff;
  rsc_pkg::rsc_init_t init_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  // supply monitor crossing
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      low_s1_ff <= 1'b0;
      low_s2_ff <= 1'b0;
    end else if (ce) begin
      low_s1_ff <= supply_low;
      low_s2_ff <= low_s1_ff;
    end
  end

  wire thr_v0 = thr_ff == `RSC_THR_V0;
  wire thr_v1 = thr_ff == `RSC_THR_V1;
  wire thr_v2 = thr_ff == `RSC_THR_V2;
  wire thr_v3 = thr_ff == `RSC_THR_V3;
  wire thr_ok = thr_v0 | thr_v1 | thr_v2 | thr_v3;
  wire [1:0] thr_sel = {thr_v2 | thr_v3, thr_v1 | thr_v3};
  wire grd_ok = (grd_ff == `RSC_GRD_RST) | (grd_ff == `RSC_GRD_ALT);
  wire wen_ok = (wen_ff == `RSC_WEN_OFF) | (wen_ff == `RSC_WEN_ON);
  wire code_bad = !thr_ok | !grd_ok | !wen_ok;

  wire mode_run = (cpu_mode == rsc_pkg::RSC_FAST) |
                  (cpu_mode == rsc_pkg::RSC_SLOW);
  wire lv_cond = low_s2_ff & mode_run & thr_ok;

  wire sr_fire = code_bad & (sr_cnt_ff == SR_N);
  wire lv_fire = lv_cond & (lv_cnt_ff == LV_N);
  wire wd_run = wdt_timeout & mode_run;
  wire wd_slp = wdt_timeout & !mode_run;
  wire nxt_full = !full_ff & (sr_fire | lv_fire | wd_run);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sr_cnt_ff <= '0;
      lv_cnt_ff <= '0;
    end else if (ce) begin
      if (full_ff) begin
        sr_cnt_ff <= '0;
        lv_cnt_ff <= '0;
      end else begin
        sr_cnt_ff <= code_bad ? sr_cnt_ff + CW'(sr_cnt_ff != SR_N) : '0;
        lv_cnt_ff <= lv_cond ? lv_cnt_ff + CW'(lv_cnt_ff != LV_N) : '0;
      end
    end
  end

  // bus decode
  wire aw_take = ce & s_awvalid & s_wvalid & !bvalid_ff;
  wire ar_take = ce & s_arvalid & !rvalid_ff;
  wire wr_lane = aw_take & s_wstrb[0];
  wire w_thr = wr_lane & (s_awaddr == `RSC_A_THR);
  wire w_flg = wr_lane & (s_awaddr == `RSC_A_FLG);
  wire w_grd = wr_lane & (s_awaddr == `RSC_A_GRD);
  wire w_wen = wr_lane & (s_awaddr == `RSC_A_WEN);
  wire aw_map = (s_awaddr == `RSC_A_THR) | (s_awaddr == `RSC_A_FLG) |
                (s_awaddr == `RSC_A_GRD) | (s_awaddr == `RSC_A_WEN) |
                (s_awaddr == `RSC_A_STS);
  wire [7:0] wd8 = s_wdata[7:0];

  wire [31:0] rd_flg = {28'h000_0000, flg_ff};
  wire [31:0] rd_sts = {30'h0000_0000, pdf_ff, to_ff};
  logic [31:0] rd_mux;
  logic rd_map;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_map = 1'b1;
    if (s_araddr == `RSC_A_THR) begin
      rd_mux = {24'h00_0000, thr_ff};
    end else if (s_araddr == `RSC_A_FLG) begin
      rd_mux = rd_flg;
    end else if (s_araddr == `RSC_A_GRD) begin
      rd_mux = {24'h00_0000, grd_ff};
    end else if (s_araddr == `RSC_A_WEN) begin
      rd_mux = {27'h000_0000, wen_ff};
    end else if (s_araddr == `RSC_A_STS) begin
      rd_mux = rd_sts;
    end else begin
      rd_map = 1'b0;
    end
  end

  // invalid code returns to power-on value
  wire thr_rst = full_ff & !lvr_cause_ff;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      thr_ff <= `RSC_THR_RST;
      grd_ff <= `RSC_GRD_RST;
      wen_ff <= `RSC_WEN_RST;
    end else if (ce) begin
      if (thr_rst) begin
        thr_ff <= `RSC_THR_RST;
      end else if (w_thr) begin
        thr_ff <= wd8;
      end
      if (full_ff) begin
        grd_ff <= `RSC_GRD_RST;
        wen_ff <= `RSC_WEN_RST;
      end else begin
        if (w_grd) begin
          grd_ff <= wd8;
        end
        if (w_wen) begin
          wen_ff <= wd8[4:0];
        end
      end
    end
  end

  // cause flags: hardware set wins over software clear
  // only a written zero clears
  wire [3:0] fl_set = {sr_fire & !grd_ok, lv_fire,
                       sr_fire & !thr_ok, sr_fire & !wen_ok};
  wire [3:0] fl_keep = w_flg ? wd8[3:0] : 4'hf;
  wire [3:0] nxt_flg = (flg_ff & fl_keep) | (nxt_full ? fl_set : 4'h0);
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flg_ff <= '0;
    end else if (ce) begin
      flg_ff <= nxt_flg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      to_ff <= 1'b0;
      pdf_ff <= 1'b0;
    end else if (ce) begin
      to_ff <= to_ff | wdt_timeout;
      pdf_ff <= pdf_ff | sleep_entry | wd_slp;
    end
  end

  // reset requests; power-on actions held through nrst
  localparam rsc_pkg::rsc_init_t INIT_FULL = '{pc_zero: 1'b1,
    sp_zero: 1'b0, sp_top: 1'b1, int_off: 1'b1, wdt_clr: 1'b1,
    tmr_off: 1'b1, io_in: 1'b1};
  localparam rsc_pkg::rsc_init_t INIT_PCSP = '{pc_zero: 1'b1,
    sp_zero: 1'b1, sp_top: 1'b0, int_off: 1'b0, wdt_clr: 1'b0,
    tmr_off: 1'b0, io_in: 1'b0};
  wire rsc_pkg::rsc_init_t nxt_init = nxt_full ? INIT_FULL :
    (wd_slp ? INIT_PCSP : '0);
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      full_ff <= 1'b0;
      lvr_cause_ff <= 1'b0;
      init_ff <= INIT_FULL;
    end else if (ce) begin
      full_ff <= nxt_full;
      lvr_cause_ff <= nxt_full & lv_fire & !sr_fire & !wd_run;
      init_ff <= nxt_init;
    end
  end

  // AXI4-Lite answers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'b00;
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      if (aw_take) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= aw_map ? 2'b00 : 2'b10;
      end else if (s_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= rd_map ? 2'b00 : 2'b10;
        rdata_ff <= rd_mux;
      end else if (s_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_awready = aw_take;
  assign s_wready = aw_take;
  assign s_arready = ar_take;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rresp = rresp_ff;
  assign s_rdata = rdata_ff;
  assign dev_reset = full_ff;
  assign init_req = init_ff;
  assign lvr_level_sel = thr_sel;
  assign wdt_enable = wen_ff == `RSC_WEN_ON;
  assign timeout_status_flag = to_ff;
  assign power_down_flag = pdf_ff;

  property p_thr_restore;
    @(posedge ref_clk) disable iff (!nrst)
    (ce && full_ff && !lvr_cause_ff) |=> thr_ff == `RSC_THR_RST;
  endproperty
  a_thr_restore: assert property (p_thr_restore)
    else $error("threshold not restored after reset");

  property p_thr_keep;
    @(posedge ref_clk) disable iff (!nrst)
    (ce && full_ff && lvr_cause_ff && !w_thr) |=> $stable(thr_ff);
  endproperty
  a_thr_keep: assert property (p_thr_keep)
    else $error("threshold lost across low-voltage reset");

  property p_low_voltage_reset_flag;
    @(posedge ref_clk) disable iff (!nrst)
    (ce && lv_fire && !full_ff) |=> flg_ff.low_voltage_reset_flag && dev_reset;
  endproperty
  a_low_voltage_reset_flag: assert property (p_low_voltage_reset_flag)
    else $error("low-voltage flag or reset missing");

  property p_flag_sticky;
    @(posedge ref_clk) disable iff (!nrst)
    (flg_ff.threshold_register_fault_flag && !w_flg) |=> flg_ff.threshold_register_fault_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("fault flag cleared without write");

  property p_rd_upper;
    @(posedge ref_clk) disable iff (!nrst)
    (ar_take && s_araddr == `RSC_A_FLG) |=> rvalid_ff &&
      rdata_ff[31:4] == 28'h000_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("upper flag bits not zero");

  property p_wd_run;
    @(posedge ref_clk) disable iff (!nrst)
    (ce && wd_run && !full_ff) |=> dev_reset && to_ff;
  endproperty
  a_wd_run: assert property (p_wd_run)
    else $error("watchdog run-mode reset missing");

  property p_wd_slp;
    @(posedge ref_clk) disable iff (!nrst)
    (ce && wd_slp && !nxt_full) |=> init_req == INIT_PCSP && to_ff &&
      pdf_ff && !dev_reset;
  endproperty
  a_wd_slp: assert property (p_wd_slp)
    else $error("sleep time-out effects wrong");

  property p_por_flags;
    @(posedge ref_clk) !nrst |=> !to_ff && !pdf_ff && init_req == INIT_FULL;
  endproperty
  a_por_flags: assert property (p_por_flags)
    else $error("power-on state wrong");

  property p_lv_mode;
    @(posedge ref_clk) disable iff (!nrst)
    !mode_run |-> !lv_fire;
  endproperty
  a_lv_mode: assert property (p_lv_mode)
    else $error("low-voltage reset in sleep");

  property p_sr_wait;
    @(posedge ref_clk) disable iff (!nrst)
    (ce && sr_fire) |-> sr_cnt_ff == SR_N && $past(code_bad);
  endproperty
  a_sr_wait: assert property (p_sr_wait)
    else $error("soft reset before delay");

  property p_lv_wait;
    @(posedge ref_clk) disable iff (!nrst)
    (ce && lv_fire) |-> lv_cnt_ff == LV_N && $past(low_s2_ff);
  endproperty
  a_lv_wait: assert property (p_lv_wait)
    else $error("low-voltage reset before debounce");

  property p_ce_hold;
    @(posedge ref_clk) disable iff (!nrst)
    !ce |=> $stable(sr_cnt_ff) && $stable(lv_cnt_ff) && $stable(flg_ff);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("state moved while clock enable low");

  property p_to_sticky;
    @(posedge ref_clk) disable iff (!nrst)
    to_ff |=> to_ff;
  endproperty
  a_to_sticky: assert property (p_to_sticky)
    else $error("time-out flag cleared without power-on");
endmodule

`default_nettype wire
